// [rtl/dtc_decoder.v]
// Behaviour
// - Four step bits form an index choosing one of sixteen preset frequencies.
// - Two ramp bits choose one of four acceleration/deceleration time sets.
// - While hold is on, a momentary forward or reverse command stays latched.
// - Coast input cuts the output immediately, raising no alarm.
// - Reset rising edge drops alarm output; falling edge clears display and hold.
// - External trip cuts output, shows trip code, asserts the alarm output.
// - External trip stays latched until an alarm reset clears it.
// - Source select on picks frequency source two, off picks source one.
// - DC brake input requests braking only when braking preconditions hold.
// - Limiter select on picks torque limit set two, else set one.
// - Run rising while switchover is on starts at 50 or 60 Hz.
// - Alarm or coast at switchover keeps output off; later start is ordinary.
// - Up/down ramps output frequency, clamped between zero and maximum.
// - Up/down ramps the PID command, clamped between zero and full scale.
// - Keypad edits are accepted only while keypad write enable is on.
// - Trip and forced stop follow a polarity set by configuration.
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_decoder #(
  parameter FREQ_W = 16,
  parameter DEB_CYCLES = (`DTC_DEB_TIME_NS * `DTC_CLK_MHZ) / 1000,
  parameter RAMP_CYCLES = (`DTC_RAMP_TIME_NS * `DTC_CLK_MHZ) / 1000
) (
  input wire clock,
  input wire nrst,
  input wire ce,
  input wire [`DTC_PIN_COUNT-1:0] terminal_pins,
  input wire trip_active_off,
  input wire stop_active_off,
  input wire brake_ready,
  input wire updown_pid_mode,
  input wire [FREQ_W-1:0] max_freq,
  input wire fault_in,
  input wire keypad_edit_req,
  input wire preset_wr_en,
  input wire [3:0] preset_wr_addr,
  input wire [FREQ_W-1:0] preset_wr_data,
  output wire [FREQ_W-1:0] preset_freq,
  output reg [3:0] step_index,
  output reg [1:0] ramp_set,
  output reg run_forward,
  output reg run_backward,
  output reg output_enable,
  output reg freq_source_select,
  output reg dc_brake_req,
  output reg torque_limit_select,
  output reg line_start,
  output reg [FREQ_W-1:0] line_freq,
  output reg [FREQ_W-1:0] updown_freq,
  output reg [FREQ_W-1:0] updown_pid,
  output reg keypad_edit_accept,
  output reg keypad_edit_reject,
  output reg general_alarm_out,
  output reg [7:0] alarm_code,
  output reg forced_stop_req
);
  localparam N = `DTC_PIN_COUNT;

  // Step toward the commanded direction, saturating at zero and at the limit.
  function [FREQ_W-1:0] ramp_step;
    input [FREQ_W-1:0] val;
    input up;
    input dn;
    input [FREQ_W-1:0] lim;
    begin
      ramp_step = val;
      if (up && !dn) begin
        if (val >= lim || lim - val < `DTC_RAMP_STEP) begin
          ramp_step = lim;
        end else begin
          ramp_step = val + `DTC_RAMP_STEP;
        end
      end else if (dn && !up) begin
        if (val < `DTC_RAMP_STEP) begin
          ramp_step = {FREQ_W{1'b0}};
        end else begin
          ramp_step = val - `DTC_RAMP_STEP;
        end
      end
    end
  endfunction

  reg [N-1:0] sync1_q, sync2_q, samp_q, clean_q, prev_q;
  reg [31:0] deb_cnt_q, ramp_cnt_q;
  reg fwd_latch_q, rev_latch_q, run_prev_q;
  reg trip_hold_q, fault_hold_q, fault_prev_q;
  wire deb_tick = (deb_cnt_q == 32'h00000000);
  wire ramp_tick = (ramp_cnt_q == 32'h00000000);
  wire [N-1:0] diff = sync2_q ^ samp_q;
  wire [N-1:0] rise = clean_q & ~prev_q;
  wire [N-1:0] fall = ~clean_q & prev_q;
  wire trip_act = clean_q[`DTC_PIN_TRIP] ^ trip_active_off;
  wire stop_act = clean_q[`DTC_PIN_STOP] ^ stop_active_off;
  wire coast = clean_q[`DTC_PIN_COAST];
  wire hold_on = clean_q[`DTC_PIN_HOLD];
  wire fwd_eff = clean_q[`DTC_PIN_FORWARD] | fwd_latch_q;
  wire rev_eff = clean_q[`DTC_PIN_BACKWARD] | rev_latch_q;
  wire run_any = fwd_eff | rev_eff;
  wire alarm_any = trip_hold_q | fault_hold_q;
  wire sw_on = clean_q[`DTC_PIN_LINE50] | clean_q[`DTC_PIN_LINE60];

  dtc_preset_mem #(.DW(FREQ_W), .AW(4)) u_mem (
    .clock(clock),
    .ce(ce),
    .wr_en(preset_wr_en),
    .wr_addr(preset_wr_addr),
    .wr_data(preset_wr_data),
    .rd_addr(clean_q[`DTC_PIN_STEP3:`DTC_PIN_STEP0]),
    .rd_data(preset_freq)
  );

  // A value is taken only after two samples one debounce period apart agree, so
  // contact bounce shorter than that period never produces a second edge.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= {N{1'b0}};
      sync2_q <= {N{1'b0}};
      samp_q <= {N{1'b0}};
      clean_q <= {N{1'b0}};
      prev_q <= {N{1'b0}};
      deb_cnt_q <= 32'h00000000;
      ramp_cnt_q <= 32'h00000000;
    end else if (ce) begin
      sync1_q <= terminal_pins;
      sync2_q <= sync1_q;
      prev_q <= clean_q;
      deb_cnt_q <= deb_tick ? DEB_CYCLES - 1 : deb_cnt_q - 32'h00000001;
      ramp_cnt_q <= ramp_tick ? RAMP_CYCLES - 1 : ramp_cnt_q - 32'h00000001;
      if (deb_tick) begin
        samp_q <= sync2_q;
        clean_q <= (sync2_q & ~diff) | (clean_q & diff);
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      step_index <= 4'h0;
      ramp_set <= 2'h0;
      freq_source_select <= 1'b0;
      torque_limit_select <= 1'b0;
      dc_brake_req <= 1'b0;
      forced_stop_req <= 1'b0;
      keypad_edit_accept <= 1'b0;
      keypad_edit_reject <= 1'b0;
    end else if (ce) begin
      step_index <= clean_q[`DTC_PIN_STEP3:`DTC_PIN_STEP0];
      ramp_set <= clean_q[`DTC_PIN_RAMP1:`DTC_PIN_RAMP0];
      freq_source_select <= clean_q[`DTC_PIN_FSRC];
      torque_limit_select <= clean_q[`DTC_PIN_TLIM];
      dc_brake_req <= clean_q[`DTC_PIN_DCB] & brake_ready;
      forced_stop_req <= stop_act;
      keypad_edit_accept <= keypad_edit_req & clean_q[`DTC_PIN_KPWE];
      keypad_edit_reject <= keypad_edit_req & ~clean_q[`DTC_PIN_KPWE];
    end
  end

  // Run commands and the line switchover start.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fwd_latch_q <= 1'b0;
      rev_latch_q <= 1'b0;
      run_prev_q <= 1'b0;
      run_forward <= 1'b0;
      run_backward <= 1'b0;
      output_enable <= 1'b0;
      line_start <= 1'b0;
      line_freq <= `DTC_RST_FREQ;
    end else if (ce) begin
      // A new momentary command replaces the opposite latched direction.
      if (!hold_on) begin
        fwd_latch_q <= 1'b0;
        rev_latch_q <= 1'b0;
      end else if (rise[`DTC_PIN_FORWARD]) begin
        fwd_latch_q <= 1'b1;
        rev_latch_q <= 1'b0;
      end else if (rise[`DTC_PIN_BACKWARD]) begin
        rev_latch_q <= 1'b1;
        fwd_latch_q <= 1'b0;
      end
      run_prev_q <= run_any;
      run_forward <= fwd_eff & ~rev_eff;
      run_backward <= rev_eff & ~fwd_eff;
      output_enable <= run_any & ~coast & ~alarm_any & ~trip_act;
      if (!run_any) begin
        line_start <= 1'b0;
      end else if (run_any && !run_prev_q && sw_on && !alarm_any && !coast) begin
        line_start <= 1'b1;
        // Only one switchover input is ever assigned, so fifty wins arbitrarily.
        line_freq <= clean_q[`DTC_PIN_LINE50] ? `DTC_FREQ_FIFTY : `DTC_FREQ_SIXTY;
      end
    end
  end

  // Alarm handling. A trip present when reset is released re-latches at once.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trip_hold_q <= 1'b0;
      fault_hold_q <= 1'b0;
      fault_prev_q <= 1'b0;
      general_alarm_out <= 1'b0;
      alarm_code <= `DTC_CODE_NONE;
    end else if (ce) begin
      fault_prev_q <= fault_in;
      if (trip_act) begin
        trip_hold_q <= 1'b1;
      end else if (fall[`DTC_PIN_ARST]) begin
        trip_hold_q <= 1'b0;
      end
      if (fault_in) begin
        fault_hold_q <= 1'b1;
      end else if (fall[`DTC_PIN_ARST]) begin
        fault_hold_q <= 1'b0;
      end
      if ((trip_act && !trip_hold_q) || (fault_in && !fault_prev_q)) begin
        general_alarm_out <= 1'b1;
      end else if (rise[`DTC_PIN_ARST]) begin
        general_alarm_out <= 1'b0;
      end
      if (trip_act) begin
        alarm_code <= `DTC_CODE_TRIP;
      end else if (fault_in && !fault_prev_q) begin
        alarm_code <= `DTC_CODE_FAULT;
      end else if (fall[`DTC_PIN_ARST]) begin
        alarm_code <= `DTC_CODE_NONE;
      end
    end
  end

  // Up/down ramping; the value not selected by the mode is held.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      updown_freq <= {FREQ_W{1'b0}};
      updown_pid <= {FREQ_W{1'b0}};
    end else if (ce && ramp_tick) begin
      if (!updown_pid_mode) begin
        updown_freq <= ramp_step(updown_freq, clean_q[`DTC_PIN_UP],
                                 clean_q[`DTC_PIN_DOWN], max_freq);
      end else begin
        updown_pid <= ramp_step(updown_pid, clean_q[`DTC_PIN_UP],
                                clean_q[`DTC_PIN_DOWN], `DTC_PID_FULL);
      end
    end
  end
endmodule

// [inc/dtc_defines.vh]
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Terminal positions within the pin vector.
`define DTC_PIN_STEP0 0
`define DTC_PIN_STEP3 3
`define DTC_PIN_RAMP0 4
`define DTC_PIN_RAMP1 5
`define DTC_PIN_HOLD 6
`define DTC_PIN_FORWARD 7
`define DTC_PIN_BACKWARD 8
`define DTC_PIN_COAST 9
`define DTC_PIN_ARST 10
`define DTC_PIN_TRIP 11
`define DTC_PIN_FSRC 12
`define DTC_PIN_DCB 13
`define DTC_PIN_TLIM 14
`define DTC_PIN_LINE50 15
`define DTC_PIN_LINE60 16
`define DTC_PIN_UP 17
`define DTC_PIN_DOWN 18
`define DTC_PIN_KPWE 19
`define DTC_PIN_STOP 20
`define DTC_PIN_COUNT 21

// Frequencies in units of 0.01 Hz, PID command in units of 0.01 %.
`define DTC_FREQ_FIFTY 16'h1388
`define DTC_FREQ_SIXTY 16'h1770
`define DTC_PID_FULL 16'h2710
`define DTC_RAMP_STEP 16'h0001

// Alarm display codes; values are arbitrary.
`define DTC_CODE_NONE 8'h00
`define DTC_CODE_TRIP 8'h02
`define DTC_CODE_FAULT 8'h01

// Timing.
`define DTC_CLK_MHZ 250
`define DTC_DEB_TIME_NS 1000000
`define DTC_RAMP_TIME_NS 1000000
`define DTC_RST_FREQ 16'h0000

`endif

// [rtl/dtc_preset_mem.v]
`timescale 1ns/1ns
module dtc_preset_mem #(
  parameter DW = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array so it maps onto plain RAM; contents are loaded before use.
  always @(posedge clock) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// [verif/dtc_decoder_asserts.sv]
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_decoder_asserts (
  input wire clock,
  input wire nrst,
  input wire keypad_edit_req,
  input wire keypad_edit_accept,
  input wire keypad_edit_reject,
  input wire brake_ready,
  input wire dc_brake_req,
  input wire [7:0] alarm_code,
  input wire output_enable,
  input wire run_forward,
  input wire run_backward,
  input wire line_start,
  input wire [15:0] line_freq,
  input wire [15:0] max_freq,
  input wire [15:0] updown_freq,
  input wire [15:0] updown_pid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence kp_ask;
    keypad_edit_req;
  endsequence
  sequence kp_one;
    keypad_edit_accept ^ keypad_edit_reject;
  endsequence
  sequence ud_move;
    $changed(updown_freq);
  endsequence
  sequence ud_size;
    16'(updown_freq - $past(updown_freq)) inside {16'h0001, 16'hffff};
  endsequence
  sequence ud_rest;
    $stable(updown_freq)[*2];
  endsequence
  kp_answer_a: assert property (kp_ask |=> kp_one)
    else $error("keypad request not answered once");
  kp_unasked_a: assert property (!$past(keypad_edit_req) |->
    !(keypad_edit_accept || keypad_edit_reject))
    else $error("keypad answer without request");
  brake_gate_a: assert property (dc_brake_req |-> $past(brake_ready))
    else $error("brake request without preconditions");
  trip_cut_a: assert property (alarm_code == `DTC_CODE_TRIP |-> !output_enable)
    else $error("output on while trip shown");
  run_excl_a: assert property (!(run_forward && run_backward))
    else $error("both run directions on");
  line_freq_a: assert property (line_start |->
    line_freq inside {`DTC_FREQ_FIFTY, `DTC_FREQ_SIXTY})
    else $error("line start at wrong frequency");
  ud_clamp_a: assert property (updown_freq <= max_freq)
    else $error("ramp frequency above maximum");
  pid_clamp_a: assert property (updown_pid <= `DTC_PID_FULL)
    else $error("pid command above full scale");
  // Two stable cycles follow a step because the bench runs the ramp tick every third cycle.
  ud_step_a: assert property (ud_move |-> ud_size ##1 ud_rest)
    else $error("ramp step size or spacing wrong");
endmodule

// [verif/dtc_term_model.sv]
`timescale 1ns/1ns
module dtc_term_model #(
  parameter HOLD = 20
) (
  input wire clock,
  output logic [20:0] pins
);
  initial pins = 21'h000000;
  // Every level is held past two debounce ticks, so no change can be lost.
  task automatic put(input logic [20:0] m, input logic [20:0] v);
    @(posedge clock);
    pins <= (pins & ~m) | (v & m);
    repeat (HOLD) @(posedge clock);
    #1;
  endtask
endmodule

// [verif/dtc_decoder_tb_top.sv]
`timescale 1ns/1ns
`include "dtc_defines.vh"
module dtc_decoder_tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic trip_active_off = 1'b0;
  logic stop_active_off = 1'b0;
  logic brake_ready = 1'b0;
  logic updown_pid_mode = 1'b0;
  logic [15:0] max_freq = 16'h0005;
  logic fault_in = 1'b0;
  logic keypad_edit_req = 1'b0;
  logic preset_wr_en = 1'b0;
  logic [3:0] preset_wr_addr = 4'h0;
  logic [15:0] preset_wr_data = 16'h0000;
  logic [20:0] v;
  wire [20:0] terminal_pins;
  wire [15:0] preset_freq, line_freq, updown_freq, updown_pid;
  wire [3:0] step_index;
  wire [1:0] ramp_set;
  wire [7:0] alarm_code;
  wire run_forward, run_backward, output_enable, freq_source_select, dc_brake_req;
  wire torque_limit_select, line_start, keypad_edit_accept, keypad_edit_reject;
  wire general_alarm_out, forced_stop_req;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int i;
  always #2 clock = ~clock;
  dtc_decoder #(.DEB_CYCLES(4), .RAMP_CYCLES(3)) dtc_decoder_inst (.clock, .nrst, .ce,
    .terminal_pins, .trip_active_off, .stop_active_off, .brake_ready, .updown_pid_mode,
    .max_freq, .fault_in, .keypad_edit_req, .preset_wr_en, .preset_wr_addr, .preset_wr_data,
    .preset_freq, .step_index, .ramp_set, .run_forward, .run_backward, .output_enable,
    .freq_source_select, .dc_brake_req, .torque_limit_select, .line_start, .line_freq,
    .updown_freq, .updown_pid, .keypad_edit_accept, .keypad_edit_reject, .general_alarm_out,
    .alarm_code, .forced_stop_req);
  dtc_term_model dtc_term_model_inst (.clock, .pins(terminal_pins));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input int b, input logic x);
    dtc_term_model_inst.put(21'h1 << b, {21{x}});
  endtask
  task automatic kp(input logic en);
    put(`DTC_PIN_KPWE, en);
    @(posedge clock);
    keypad_edit_req <= 1'b1;
    @(posedge clock);
    keypad_edit_req <= 1'b0;
    #1;
    chk(keypad_edit_accept, en);
    chk(keypad_edit_reject, !en);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 17; i++) begin
      @(posedge clock);
      preset_wr_en <= (i < 16);
      preset_wr_addr <= i[3:0];
      preset_wr_data <= 16'h0100 + i[15:0];
    end
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      brake_ready <= i[1];
      v = (i[0] ? 21'h007000 : 21'h000000) | (i[1:0] << 4) | i[3:0];
      dtc_term_model_inst.put(21'h00703f, v);
      chk(step_index, i[3:0]);
      chk(preset_freq, 16'h0100 + i[15:0]);
      chk(ramp_set, i[1:0]);
      chk(freq_source_select, i[0]);
      chk(torque_limit_select, i[0]);
      chk(dc_brake_req, i[0] & i[1]);
    end
    // With the enable low nothing may move, the pin change is seen only after it rises.
    @(posedge clock);
    ce <= 1'b0;
    put(`DTC_PIN_STEP0, 1'b0);
    chk({step_index, preset_freq}, 20'hf010f);
    @(posedge clock);
    ce <= 1'b1;
    repeat (20) @(posedge clock);
    #1;
    chk({step_index, preset_freq}, 20'he010e);
    put(`DTC_PIN_HOLD, 1'b1);
    put(`DTC_PIN_FORWARD, 1'b1);
    put(`DTC_PIN_FORWARD, 1'b0);
    chk(run_forward, 1'b1);
    chk(output_enable, 1'b1);
    put(`DTC_PIN_BACKWARD, 1'b1);
    put(`DTC_PIN_BACKWARD, 1'b0);
    chk({run_forward, run_backward}, 2'h1);
    put(`DTC_PIN_COAST, 1'b1);
    chk({output_enable, general_alarm_out, alarm_code}, 16'h0000);
    put(`DTC_PIN_COAST, 1'b0);
    chk(output_enable, 1'b1);
    @(posedge clock);
    trip_active_off <= 1'b1;
    put(`DTC_PIN_TRIP, 1'b0);
    chk({general_alarm_out, output_enable, alarm_code}, 16'h0202);
    put(`DTC_PIN_TRIP, 1'b1);
    chk({general_alarm_out, output_enable, alarm_code}, 16'h0202);
    put(`DTC_PIN_ARST, 1'b1);
    chk({general_alarm_out, alarm_code}, 16'h0002);
    put(`DTC_PIN_ARST, 1'b0);
    chk(alarm_code, `DTC_CODE_NONE);
    chk(output_enable, 1'b1);
    @(posedge clock);
    stop_active_off <= 1'b1;
    put(`DTC_PIN_STOP, 1'b0);
    chk(forced_stop_req, 1'b1);
    put(`DTC_PIN_STOP, 1'b1);
    chk(forced_stop_req, 1'b0);
    @(posedge clock);
    fault_in <= 1'b1;
    @(posedge clock);
    fault_in <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({general_alarm_out, output_enable, alarm_code}, 16'h0201);
    put(`DTC_PIN_ARST, 1'b1);
    put(`DTC_PIN_ARST, 1'b0);
    chk({general_alarm_out, output_enable, alarm_code}, 16'h0100);
    kp(1'b0);
    kp(1'b1);
    put(`DTC_PIN_HOLD, 1'b0);
    put(`DTC_PIN_LINE50, 1'b1);
    put(`DTC_PIN_FORWARD, 1'b1);
    chk({line_start, line_freq}, {1'b1, `DTC_FREQ_FIFTY});
    put(`DTC_PIN_FORWARD, 1'b0);
    chk(line_start, 1'b0);
    put(`DTC_PIN_LINE50, 1'b0);
    put(`DTC_PIN_LINE60, 1'b1);
    put(`DTC_PIN_FORWARD, 1'b1);
    chk({line_start, line_freq}, {1'b1, `DTC_FREQ_SIXTY});
    put(`DTC_PIN_FORWARD, 1'b0);
    put(`DTC_PIN_COAST, 1'b1);
    put(`DTC_PIN_FORWARD, 1'b1);
    chk({line_start, output_enable}, 2'h0);
    put(`DTC_PIN_COAST, 1'b0);
    chk({line_start, output_enable}, 2'h1);
    put(`DTC_PIN_FORWARD, 1'b0);
    put(`DTC_PIN_LINE60, 1'b0);
    put(`DTC_PIN_UP, 1'b1);
    repeat (30) @(posedge clock);
    chk(updown_freq, 16'h0005);
    put(`DTC_PIN_UP, 1'b0);
    put(`DTC_PIN_DOWN, 1'b1);
    repeat (30) @(posedge clock);
    chk(updown_freq, 16'h0000);
    put(`DTC_PIN_DOWN, 1'b0);
    @(posedge clock);
    updown_pid_mode <= 1'b1;
    put(`DTC_PIN_UP, 1'b1);
    repeat (30100) @(posedge clock);
    chk(updown_pid, `DTC_PID_FULL);
    chk(updown_freq, 16'h0000);
    print_verdict();
  end
endmodule
bind dtc_decoder dtc_decoder_asserts dtc_decoder_asserts_inst (.clock, .nrst, .keypad_edit_req,
  .keypad_edit_accept, .keypad_edit_reject, .brake_ready, .dc_brake_req, .alarm_code,
  .output_enable, .run_forward, .run_backward, .line_start, .line_freq, .max_freq,
  .updown_freq, .updown_pid);
